//--- include/rnsa_defines.svh
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 50 MHz clock, 32-bit register bus
// Notes:   Definitions only
`ifndef RNSA_DEFINES_SVH
`define RNSA_DEFINES_SVH

// Register byte offsets
`define RNSA_OFS_CTRL        8'h00
`define RNSA_OFS_STATUS      8'h04
`define RNSA_OFS_IRQ_STATUS  8'h08
`define RNSA_OFS_IRQ_MASK    8'h0c
`define RNSA_OFS_NODE_LIGHTS 8'h10
`define RNSA_OFS_HEX_CODE    8'h14
`define RNSA_OFS_BRANCH      8'h18

// Control fields
`define RNSA_CTRL_FORCE_INT  0
`define RNSA_CTRL_REDUCED    1
`define RNSA_CTRL_RESET      2'h0

// Interrupt event bits
`define RNSA_EV_COMM_LOST    0
`define RNSA_EV_LINK_LOST    1
`define RNSA_EV_POWER_LOST   2
`define RNSA_EV_INT_FAULT    3
`define RNSA_EV_WIDTH        4

// Legacy bus address window, inclusive
`define RNSA_LEGACY_LO       8'h08
`define RNSA_LEGACY_HI       8'hfb

// Switch positions that alias onto low addresses
`define RNSA_SW_ALIAS_BASE   4'h8

// Timing
`define RNSA_CLK_KHZ         50000
`define RNSA_COMM_TIMEOUT_MS 1000
`define RNSA_OBS_INTERVAL_MS 100
`define RNSA_COMM_TIMEOUT_CYC (`RNSA_COMM_TIMEOUT_MS * `RNSA_CLK_KHZ)
`define RNSA_OBS_INTERVAL_CYC (`RNSA_OBS_INTERVAL_MS * `RNSA_CLK_KHZ)

`endif

//--- include/rnsa_pkg.sv
// Purpose: Types shared by the remote node status block
// Assumes: Nothing beyond the defines header
// Notes:   Types only; numbers live in rnsa_defines.svh
package rnsa_pkg;

  typedef struct packed {
    logic int_red;
    logic ext_red;
    logic comm_green;
    logic pwr_green;
  } rnsa_unit_led_type;

  typedef struct packed {
    logic [7:0] green;
    logic [7:0] red;
  } rnsa_branch_led_type;

  typedef struct packed {
    logic       second_link_port;
    logic [1:0] channel;
    logic [2:0] address;
  } rnsa_route_type;

endpackage

//--- rtl/rnsa_top.sv
// Purpose: Remote node addressing, link health and status indicators
// Assumes: All inputs synchronous to clock; AHB-Lite slave, zero wait states
// Notes:   Long counts are parameters so simulation can shorten them
//
// Decided for this implementation: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps
`include "rnsa_defines.svh"

module rnsa_top #(
  parameter int unsigned COMM_TIMEOUT_CYC = `RNSA_COMM_TIMEOUT_CYC,
  parameter int unsigned OBS_INTERVAL_CYC = `RNSA_OBS_INTERVAL_CYC,
  parameter int unsigned NUM_BRANCHES     = 8,
  parameter int unsigned NUM_CHANNELS     = 4
) (
  // Clock and reset
  input  wire logic                         clock,
  input  wire logic                         resetn,
  // AHB-Lite slave
  input  wire logic                         hsel,
  input  wire logic [31:0]                  haddr,
  input  wire logic [1:0]                   htrans,
  input  wire logic                         hwrite,
  input  wire logic [2:0]                   hsize,
  input  wire logic [31:0]                  hwdata,
  input  wire logic                         hready,
  output logic      [31:0]                  hrdata,
  output logic                              hreadyout,
  output logic                              hresp,
  output logic                              irq,
  // Node address switch and routing
  input  wire logic [3:0]                   rotary_switch,
  output rnsa_pkg::rnsa_route_type          node_route,
  // Controller accesses and legacy bus
  input  wire logic                         ctrl_access,
  input  wire logic                         legacy_strobe,
  input  wire logic [7:0]                   legacy_addr,
  output logic                              legacy_select,
  // Node health sources
  input  wire logic                         internal_error,
  input  wire logic                         link_healthy,
  input  wire logic                         vcc_above_min,
  // Media unit receivers
  input  wire logic [NUM_CHANNELS-1:0]      rx_light_above,
  output logic      [NUM_CHANNELS-1:0]      link_ok_led,
  // Branch I/O cycle results
  input  wire logic [NUM_BRANCHES-1:0]      branch_cycle_done,
  input  wire logic [NUM_BRANCHES-1:0]      branch_cycle_ok,
  // Indicators
  output rnsa_pkg::rnsa_unit_led_type       unit_led,
  output rnsa_pkg::rnsa_branch_led_type     branch_led,
  output logic      [7:0]                   node_lights,
  output logic      [7:0]                   hex_display
);
  import rnsa_pkg::*;

  localparam int unsigned COMM_W = $clog2(COMM_TIMEOUT_CYC + 1);
  localparam int unsigned OBS_W  = $clog2(OBS_INTERVAL_CYC + 1);
  // Reduced media unit has only the first two channels fitted
  localparam int unsigned REDUCED_CHANNELS = 2;

  function automatic logic [2:0] switch_to_address(input logic [3:0] sw);
    if (sw >= `RNSA_SW_ALIAS_BASE) begin
      switch_to_address = {2'b00, sw[0]};
    end else begin
      switch_to_address = sw[2:0];
    end
  endfunction

  function automatic logic in_legacy_window(input logic [7:0] a);
    in_legacy_window = (a >= `RNSA_LEGACY_LO) && (a <= `RNSA_LEGACY_HI);
  endfunction

  // Registers live in the lowest 256 bytes; anything above reads zero
  function automatic logic in_reg_page(input logic [31:0] a);
    in_reg_page = (a[31:8] == 24'h00_0000);
  endfunction

  // Bus state
  logic                         wr_pend_q;
  logic [7:0]                   wr_addr_q;
  logic [1:0]                   ctrl_q;
  logic [`RNSA_EV_WIDTH-1:0]    irq_status_q;
  logic [`RNSA_EV_WIDTH-1:0]    irq_mask_q;
  logic [7:0]                   node_lights_q;
  logic [7:0]                   hex_code_q;
  logic [31:0]                  rdata_q;
  logic                         addr_phase;
  logic [7:0]                   rd_ofs;

  // Status state
  rnsa_route_type               route_q;
  logic [COMM_W-1:0]            comm_cnt_q;
  logic                         comm_green;
  logic [NUM_CHANNELS-1:0]      link_ok_q;
  rnsa_unit_led_type            unit_led_q;
  rnsa_unit_led_type            unit_prev_q;
  logic [OBS_W-1:0]             obs_cnt_q;
  logic                         obs_tick;
  logic [NUM_BRANCHES-1:0]      seen_ok_q;
  logic [NUM_BRANCHES-1:0]      seen_fail_q;
  logic [NUM_BRANCHES-1:0]      br_green_q;
  logic [NUM_BRANCHES-1:0]      br_red_q;
  logic                         legacy_sel_q;
  logic                         legacy_hit;
  logic [`RNSA_EV_WIDTH-1:0]    events;
  logic [2:0]                   node_addr;
  logic                         irq_q;
  logic                         led_seen_q;
  logic                         prev_seen_q;

  assign hreadyout  = 1'b1;
  assign hresp      = 1'b0;
  assign addr_phase = hsel && htrans[1] && hready;
  assign rd_ofs     = haddr[7:0];

  // Address phase: latch writes, fetch read data so it stands in data phase
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end else if (hready) begin
      wr_pend_q <= addr_phase && hwrite && in_reg_page(haddr);
      wr_addr_q <= haddr[7:0];
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rdata_q <= 32'h0000_0000;
    end else if (addr_phase && !hwrite) begin
      if (!in_reg_page(haddr)) begin
        rdata_q <= 32'h0000_0000;
      end else if (rd_ofs == `RNSA_OFS_CTRL) begin
        rdata_q <= {30'h0, ctrl_q};
      end else if (rd_ofs == `RNSA_OFS_STATUS) begin
        rdata_q <= {16'h0, unit_led_q, 4'(link_ok_q),
                    2'b00, route_q};
      end else if (rd_ofs == `RNSA_OFS_IRQ_STATUS) begin
        rdata_q <= {28'h0, irq_status_q};
      end else if (rd_ofs == `RNSA_OFS_IRQ_MASK) begin
        rdata_q <= {28'h0, irq_mask_q};
      end else if (rd_ofs == `RNSA_OFS_NODE_LIGHTS) begin
        rdata_q <= {24'h0, node_lights_q};
      end else if (rd_ofs == `RNSA_OFS_HEX_CODE) begin
        rdata_q <= {24'h0, hex_code_q};
      end else if (rd_ofs == `RNSA_OFS_BRANCH) begin
        rdata_q <= {16'h0, 8'(br_green_q),
                    8'(br_red_q)};
      end else begin
        rdata_q <= 32'h0000_0000;
      end
    end
  end
  assign hrdata = rdata_q;

  // Data phase writes; unmapped offsets are ignored
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ctrl_q        <= `RNSA_CTRL_RESET;
      irq_mask_q    <= 4'h0;
      node_lights_q <= 8'h00;
      hex_code_q    <= 8'h00;
    end else if (wr_pend_q) begin
      if (wr_addr_q == `RNSA_OFS_CTRL) begin
        ctrl_q <= hwdata[1:0];
      end else if (wr_addr_q == `RNSA_OFS_IRQ_MASK) begin
        irq_mask_q <= hwdata[`RNSA_EV_WIDTH-1:0];
      end else if (wr_addr_q == `RNSA_OFS_NODE_LIGHTS) begin
        node_lights_q <= hwdata[7:0];
      end else if (wr_addr_q == `RNSA_OFS_HEX_CODE) begin
        hex_code_q <= hwdata[7:0];
      end
    end
  end
  assign node_lights = node_lights_q;
  assign hex_display = hex_code_q;

  // Node address and path; 3-bit address caps the system at eight nodes
  assign node_addr = switch_to_address(rotary_switch);
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      route_q <= '0;
    end else begin
      route_q.address          <= node_addr;
      route_q.channel          <= node_addr[1:0];
      route_q.second_link_port <= node_addr[2];
    end
  end
  assign node_route = route_q;

  // Legacy bus decode
  assign legacy_hit = legacy_strobe && in_legacy_window(legacy_addr);
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      legacy_sel_q <= 1'b0;
    end else begin
      legacy_sel_q <= legacy_hit;
    end
  end
  assign legacy_select = legacy_sel_q;

  // Communication watchdog, reloaded by any valid access
  // Reload beats the countdown, so accesses one timeout apart keep it lit
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      comm_cnt_q <= '0;
    end else if (ctrl_access || legacy_hit) begin
      comm_cnt_q <= COMM_W'(COMM_TIMEOUT_CYC);
    end else if (comm_cnt_q != '0) begin
      comm_cnt_q <= comm_cnt_q - 1'b1;
    end
  end
  assign comm_green = (comm_cnt_q != '0);

  // Media unit link indicators; reduced variant has no channels 3 and 4
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      link_ok_q <= '0;
    end else begin
      for (int i = 0; i < NUM_CHANNELS; i++) begin
        link_ok_q[i] <= rx_light_above[i]
                        && !(ctrl_q[`RNSA_CTRL_REDUCED] && i >= REDUCED_CHANNELS);
      end
    end
  end
  assign link_ok_led = link_ok_q;

  // Unit indicators
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      unit_led_q <= '0;
    end else begin
      unit_led_q.int_red    <= !comm_green || ctrl_q[`RNSA_CTRL_FORCE_INT]
                               || internal_error;
      unit_led_q.ext_red    <= !link_healthy;
      unit_led_q.comm_green <= comm_green;
      unit_led_q.pwr_green  <= vcc_above_min;
    end
  end
  assign unit_led = unit_led_q;

  // Observation interval for branch results
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      obs_cnt_q <= '0;
    end else if (obs_tick) begin
      obs_cnt_q <= '0;
    end else begin
      obs_cnt_q <= obs_cnt_q + 1'b1;
    end
  end
  assign obs_tick = (obs_cnt_q == OBS_W'(OBS_INTERVAL_CYC - 1));

  // Results arriving on the tick count toward the interval just ending
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      seen_ok_q   <= '0;
      seen_fail_q <= '0;
      br_green_q  <= '0;
      br_red_q    <= '0;
    end else if (obs_tick) begin
      br_green_q  <= seen_ok_q | (branch_cycle_done & branch_cycle_ok);
      br_red_q    <= seen_fail_q | (branch_cycle_done & ~branch_cycle_ok);
      seen_ok_q   <= '0;
      seen_fail_q <= '0;
    end else begin
      seen_ok_q   <= seen_ok_q | (branch_cycle_done & branch_cycle_ok);
      seen_fail_q <= seen_fail_q | (branch_cycle_done & ~branch_cycle_ok);
    end
  end
  // One driver for the whole struct; narrower builds pad with zeros
  assign branch_led = '{green: 8'(br_green_q),
                        red:   8'(br_red_q)};

  // Interrupt events on indicator degradation
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      unit_prev_q <= '0;
    end else begin
      unit_prev_q <= unit_led_q;
    end
  end

  // Indicators leave reset at zero and take their idle state one edge later;
  // events wait until the history register holds a real sample, so a reset
  // does not raise a fault event of its own
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      led_seen_q  <= 1'b0;
      prev_seen_q <= 1'b0;
    end else begin
      led_seen_q  <= 1'b1;
      prev_seen_q <= led_seen_q;
    end
  end

  always_comb begin
    events = '0;
    if (prev_seen_q) begin
      events[`RNSA_EV_COMM_LOST]  = unit_prev_q.comm_green && !unit_led_q.comm_green;
      events[`RNSA_EV_LINK_LOST]  = !unit_prev_q.ext_red && unit_led_q.ext_red;
      events[`RNSA_EV_POWER_LOST] = unit_prev_q.pwr_green && !unit_led_q.pwr_green;
      events[`RNSA_EV_INT_FAULT]  = !unit_prev_q.int_red && unit_led_q.int_red;
    end
  end

  // Set wins over a same-cycle write-one-to-clear
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      irq_status_q <= '0;
    end else if (wr_pend_q && wr_addr_q == `RNSA_OFS_IRQ_STATUS) begin
      irq_status_q <= (irq_status_q & ~hwdata[`RNSA_EV_WIDTH-1:0]) | events;
    end else begin
      irq_status_q <= irq_status_q | events;
    end
  end

  // Registered so the pin cannot glitch while status and mask change
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(irq_status_q & irq_mask_q);
    end
  end
  assign irq = irq_q;

endmodule

//--- tb/rnsa_top_monitor.sv
// Purpose: Checker on the rnsa_top ports
// Assumes: One clock, resetn async active low
// Notes:   Tick counter mirrors the branch interval
`timescale 1ns/1ps
module rnsa_top_monitor #(
  parameter int unsigned COMM_TIMEOUT_CYC = 50,
  parameter int unsigned OBS_INTERVAL_CYC = 20
) (
  // Clock and reset
  input wire logic                          clock,
  input wire logic                          resetn,
  // Addressing and accesses
  input wire logic [3:0]                    rotary_switch,
  input wire rnsa_pkg::rnsa_route_type      node_route,
  input wire logic                          ctrl_access,
  input wire logic                          legacy_strobe,
  input wire logic [7:0]                    legacy_addr,
  input wire logic                          legacy_select,
  // Health and indicators
  input wire logic                          internal_error,
  input wire logic                          link_healthy,
  input wire logic                          vcc_above_min,
  input wire logic [3:0]                    rx_light_above,
  input wire logic [3:0]                    link_ok_led,
  input wire rnsa_pkg::rnsa_unit_led_type   unit_led,
  input wire rnsa_pkg::rnsa_branch_led_type branch_led
);
  import rnsa_pkg::*;
  logic [31:0] tick_q;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      tick_q <= 32'h0;
    end else begin
      tick_q <= (tick_q == OBS_INTERVAL_CYC - 1) ? 32'h0 : tick_q + 32'h1;
    end
  end
  sequence s_hit;
    ctrl_access;
  endsequence
  sequence s_lit;
    ##2 unit_led.comm_green [*3];
  endsequence
  route_addr_a: assert property ($past(resetn) |-> node_route.address ==
    ($past(rotary_switch) < 4'h8 ? $past(rotary_switch[2:0]) : {2'h0, $past(rotary_switch[0])}))
    else $error("node address wrong for switch");
  route_port_a: assert property (node_route.channel == node_route.address[1:0] &&
    node_route.second_link_port == node_route.address[2]) else $error("port or channel wrong");
  legacy_sel_a: assert property ($past(resetn) |-> legacy_select ==
    $past(legacy_strobe && legacy_addr >= 8'h08 && legacy_addr <= 8'hfb))
    else $error("legacy select wrong");
  link_led_a: assert property ($past(resetn) |-> link_ok_led[1:0] == $past(rx_light_above[1:0]))
    else $error("link led wrong");
  ext_fault_a: assert property ($past(resetn) |-> unit_led.ext_red == !$past(link_healthy))
    else $error("external red wrong");
  power_led_a: assert property ($past(resetn) |-> unit_led.pwr_green == $past(vcc_above_min))
    else $error("power green wrong");
  int_fault_a: assert property ($past(resetn) &&
    (!unit_led.comm_green || $past(internal_error)) |-> unit_led.int_red)
    else $error("internal red missing");
  comm_up_a: assert property (s_hit |-> s_lit) else $error("comm green missing");
  branch_tick_a: assert property ($changed(branch_led) |-> tick_q == 32'h0)
    else $error("branch leds changed off tick");
endmodule
bind rnsa_top rnsa_top_monitor #(
  .COMM_TIMEOUT_CYC(COMM_TIMEOUT_CYC),
  .OBS_INTERVAL_CYC(OBS_INTERVAL_CYC)
) u_rnsa_top_monitor (
  .clock, .resetn, .rotary_switch, .node_route, .ctrl_access, .legacy_strobe,
  .legacy_addr, .legacy_select, .internal_error, .link_healthy, .vcc_above_min,
  .rx_light_above, .link_ok_led, .unit_led, .branch_led
);

//--- tb/rnsa_ctrl_model.sv
// Purpose: Controller card polling the node
// Assumes: Pulses of one cycle on the clock
// Notes:   Stops polling when disabled, so the node times out
`timescale 1ns/1ps
module rnsa_ctrl_model (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       resetn,
  // Polling control
  input  wire logic       poll_en,
  input  wire logic [7:0] gap,
  // Access to the node
  output logic            ctrl_access
);
  logic [7:0] cnt_q;
  // Access every gap+1 cycles while polling
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cnt_q       <= 8'h00;
      ctrl_access <= 1'b0;
    end else begin
      ctrl_access <= poll_en && cnt_q == 8'h00;
      cnt_q       <= (!poll_en || cnt_q == gap) ? 8'h00 : cnt_q + 8'h01;
    end
  end
endmodule

//--- tb/tb.sv
// Purpose: Self-checking bench for rnsa_top
// Assumes: Zero-wait bus slave, shortened counts
// Notes:   Polling comes from the controller model
`timescale 1ns/1ps
`include "rnsa_defines.svh"
module tb;
  import rnsa_pkg::*;
  localparam int unsigned COMM = 50;
  localparam int unsigned OBS  = 20;
  typedef struct packed {
    logic [3:0] sw;
    logic [5:0] route;
  } rnsa_row_type;
  rnsa_row_type        rows [10] = '{'{4'h0, 6'h00}, '{4'h1, 6'h09}, '{4'h2, 6'h12},
    '{4'h3, 6'h1b}, '{4'h4, 6'h24}, '{4'h5, 6'h2d}, '{4'h6, 6'h36}, '{4'h7, 6'h3f},
    '{4'h8, 6'h00}, '{4'h9, 6'h09}};
  logic [7:0]          la [4] = '{8'h07, 8'h08, 8'hfb, 8'hfc};
  logic                ls [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
  logic                clock = 1'b0, resetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic                poll_en = 1'b0, legacy_strobe = 1'b0, internal_error = 1'b0;
  logic                link_healthy = 1'b1, vcc_above_min = 1'b1;
  logic                hready, hresp, irq, ctrl_access, legacy_select;
  logic [1:0]          htrans = 2'h0;
  logic [3:0]          rotary_switch = 4'h0, rx_light_above = 4'h0, link_ok_led;
  logic [7:0]          legacy_addr = 8'h00, done = 8'h00, ok = 8'h00, node_lights, hex_display;
  logic [31:0]         haddr = 32'h0, hwdata = 32'h0, hrdata, rv;
  rnsa_route_type      node_route;
  rnsa_unit_led_type   unit_led;
  rnsa_branch_led_type branch_led;
  int                  failures = 0, cmp_count = 0, cyc = 0;
  rnsa_top #(.COMM_TIMEOUT_CYC(COMM), .OBS_INTERVAL_CYC(OBS)) u_rnsa_top (
    .clock, .resetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready,
    .hrdata, .hreadyout(hready), .hresp, .irq, .rotary_switch, .node_route, .ctrl_access,
    .legacy_strobe, .legacy_addr, .legacy_select, .internal_error, .link_healthy,
    .vcc_above_min, .rx_light_above, .link_ok_led, .branch_cycle_done(done),
    .branch_cycle_ok(ok), .unit_led, .branch_led, .node_lights, .hex_display);
  rnsa_ctrl_model u_rnsa_ctrl_model (.clock, .resetn, .poll_en, .gap(8'h09), .ctrl_access);
  always #10 clock = ~clock;
  always @(posedge clock) cyc <= resetn ? cyc + 1 : 0;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Address phase held until hready, then data phase until hready
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clock);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr  <= 32'(a);
    do @(posedge clock); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clock); while (hready !== 1'b1);
    rv = hrdata;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clock);
    @(negedge clock);
  endtask
  // Interval phase is only known to within a cycle, so aim two cycles past the interval start
  task automatic wait_phase(input int p);
    do @(negedge clock); while (cyc % OBS != p);
    @(posedge clock);
  endtask
  initial begin
    #100us;
    failures++;
    test_done;
  end
  initial begin
    repeat (2) @(posedge clock);
    resetn <= 1'b1;
    settle(1);
    check(32'({unit_led, irq, node_lights}), 32'h1200);
    foreach (rows[i]) begin
      @(posedge clock);
      rotary_switch <= rows[i].sw;
      bus(1'b0, `RNSA_OFS_STATUS, 32'h0);
      check(32'(rv[5:0]), 32'(rows[i].route));
      check(32'(node_route), 32'(rows[i].route));
    end
    bus(1'b1, `RNSA_OFS_NODE_LIGHTS, 32'ha5);
    bus(1'b1, `RNSA_OFS_HEX_CODE, 32'h3c);
    bus(1'b1, 8'h1c, 32'hff);
    bus(1'b0, 8'h1c, 32'h0);
    check(rv, 32'h0);
    check(32'({node_lights, hex_display, hready, hresp}), 32'h294f2);
    rx_light_above <= 4'hb;
    settle(2);
    check(32'(link_ok_led), 32'hb);
    bus(1'b1, `RNSA_OFS_CTRL, 32'h2);
    settle(1);
    check(32'(link_ok_led), 32'h3);
    bus(1'b1, `RNSA_OFS_CTRL, 32'h0);
    for (int i = 0; i < 4; i++) begin
      @(posedge clock);
      legacy_strobe <= 1'b1;
      legacy_addr   <= la[i];
      @(posedge clock);
      legacy_strobe <= 1'b0;
      @(negedge clock);
      check(32'(legacy_select), 32'(ls[i]));
    end
    @(posedge clock);
    poll_en <= 1'b1;
    settle(20);
    check(32'(unit_led), 32'h3);
    bus(1'b1, `RNSA_OFS_CTRL, 32'h1);
    settle(1);
    check(32'(unit_led), 32'hb);
    bus(1'b1, `RNSA_OFS_CTRL, 32'h0);
    internal_error <= 1'b1;
    settle(1);
    check(32'(unit_led), 32'hb);
    @(posedge clock);
    internal_error <= 1'b0;
    poll_en        <= 1'b0;
    settle(COMM - 12);
    check(32'(unit_led), 32'h3);
    settle(20);
    check(32'(unit_led), 32'h9);
    bus(1'b1, `RNSA_OFS_IRQ_STATUS, 32'hf);
    link_healthy <= 1'b0;
    settle(3);
    check(32'({unit_led.ext_red, irq}), 32'h2);
    bus(1'b1, `RNSA_OFS_IRQ_MASK, 32'h2);
    settle(1);
    check(32'(irq), 32'h1);
    bus(1'b1, `RNSA_OFS_IRQ_STATUS, 32'h2);
    settle(1);
    check(32'(irq), 32'h0);
    @(posedge clock);
    link_healthy  <= 1'b1;
    vcc_above_min <= 1'b0;
    settle(2);
    check(32'(unit_led.pwr_green), 32'h0);
    wait_phase(2);
    done <= 8'h07;
    ok   <= 8'h05;
    @(posedge clock);
    done <= 8'h04;
    ok   <= 8'h00;
    @(posedge clock);
    done <= 8'h00;
    wait_phase(2);
    @(negedge clock);
    check(32'(branch_led), 32'h0506);
    bus(1'b0, `RNSA_OFS_BRANCH, 32'h0);
    check(rv, 32'h0506);
    wait_phase(2);
    @(negedge clock);
    check(32'(branch_led), 32'h0);
    @(posedge clock);
    resetn <= 1'b0;
    settle(1);
    check(32'({unit_led, node_lights, irq}), 32'h0);
    @(posedge clock);
    resetn <= 1'b1;
    settle(1);
    check(32'(unit_led), 32'h8);
    test_done;
  end
endmodule
